// ### src/bmrs_defs.svh
`ifndef BMRS_DEFS_SVH
`define BMRS_DEFS_SVH

// Time base
`define BMRS_CLK_KHZ 100000

// Qualification time of every low-battery flag
`define BMRS_LB_TIMEOUT_MS 150
`define BMRS_LB_CYC (`BMRS_LB_TIMEOUT_MS * `BMRS_CLK_KHZ)

// Supply reset timeout (150 or 1200 ms options)
`define BMRS_RST_TIMEOUT_MS 150
`define BMRS_RST_CYC (`BMRS_RST_TIMEOUT_MS * `BMRS_CLK_KHZ)

// Manual reset pulse length
`define BMRS_MR_TIMEOUT_MS 150
`define BMRS_MR_CYC (`BMRS_MR_TIMEOUT_MS * `BMRS_CLK_KHZ)

// Manual reset rising debounce period
`define BMRS_DEB_TIMEOUT_MS 150
`define BMRS_DEB_CYC (`BMRS_DEB_TIMEOUT_MS * `BMRS_CLK_KHZ)

// Synchroniser bit positions and reset values
`define BMRS_SYN_LOW 0
`define BMRS_SYN_HIGH 1
`define BMRS_SYN_SUPPLY 2
`define BMRS_SYN_MR 3
`define BMRS_SYN_RST 4'h8

`endif

// ### src/bmrs_pkg.sv
package bmrs_pkg;

  // Supply supervisor states
  typedef enum logic [2:0] {
    RS_LOW  = 3'h1,
    RS_WAIT = 3'h2,
    RS_OK   = 3'h4
  } bmrs_rs_state_t;

  // Output enables of the open-drain battery flags
  typedef struct packed {
    logic low_battery;
    logic battery_weak;
    logic battery_empty;
  } bmrs_flags_t;

  // Synchronised comparator results
  typedef struct packed {
    logic mr_n;
    logic supply_ok;
    logic high_above;
    logic low_above;
  } bmrs_cmp_t;

endpackage

// ### src/bmrs_top.sv
`timescale 1ns/1ps
`include "bmrs_defs.svh"

module bmrs_top #(
  parameter bit DUAL_FLAG = 1'h0,
  parameter bit PUSH_PULL = 1'h0,
  parameter int LB_CYC = `BMRS_LB_CYC,
  parameter int RST_CYC = `BMRS_RST_CYC,
  parameter int MR_CYC = `BMRS_MR_CYC,
  parameter int DEB_CYC = `BMRS_DEB_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic low_thr_above_in,
  input wire logic high_thr_above_in,
  input wire logic supply_ok_in,
  input wire logic manual_reset_n_in,
  output bmrs_pkg::bmrs_flags_t flag_oe_out,
  output logic flag_level_out,
  output logic processor_reset_n_out,
  output logic processor_reset_oe_out
);
  import bmrs_pkg::*;

  localparam int LBW = $clog2(LB_CYC + 1);
  localparam int RSW = $clog2(RST_CYC + 1);
  localparam int MRW = $clog2(MR_CYC + 1);
  localparam int DBW = $clog2(DEB_CYC + 1);
  localparam logic [3:0] SYN_RST = `BMRS_SYN_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [3:0] raw_w;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  bmrs_cmp_t cmp_w;

  assign raw_w[`BMRS_SYN_LOW] = low_thr_above_in;
  assign raw_w[`BMRS_SYN_HIGH] = high_thr_above_in;
  assign raw_w[`BMRS_SYN_SUPPLY] = supply_ok_in;
  assign raw_w[`BMRS_SYN_MR] = manual_reset_n_in;
  assign cmp_w = sync2_q;

  // Two flops per input; manual reset idles high
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        sync1_q[i] <= SYN_RST[i];
        sync2_q[i] <= SYN_RST[i];
      end else begin
        sync1_q[i] <= raw_w[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Battery flag qualification (channel 0: combined or empty, 1: weak)

  logic [1:0] set_w;
  logic [1:0] qual_w;
  logic [1:0] flag_q;
  logic [LBW-1:0] cnt_q [2];

  // Single variant: low input sets, high input qualifies the release
  assign set_w[0] = ~cmp_w.low_above;
  assign qual_w[0] = DUAL_FLAG ? cmp_w.low_above : cmp_w.high_above;
  assign set_w[1] = DUAL_FLAG & ~cmp_w.high_above;
  // Weak timer waits for the empty flag so releases come in order
  assign qual_w[1] = DUAL_FLAG & cmp_w.high_above & ~flag_q[0];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic done_w;
    assign done_w = qual_w[c] && (cnt_q[c] == LBW'(LB_CYC - 1));

    // Set wins over release; any drop clears the count
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        flag_q[c] <= 1'h1;
        cnt_q[c] <= '0;
      end else if (set_w[c] || !flag_q[c]) begin
        flag_q[c] <= set_w[c];
        cnt_q[c] <= '0;
      end else if (!qual_w[c]) begin
        cnt_q[c] <= '0;
      end else if (done_w) begin
        flag_q[c] <= 1'h0;
        cnt_q[c] <= '0;
      end else begin
        cnt_q[c] <= cnt_q[c] + LBW'(1);
      end
    end
  end

  // Open-drain flags: only the enable moves, the level stays low
  assign flag_oe_out.low_battery = ~DUAL_FLAG & flag_q[0];
  assign flag_oe_out.battery_empty = DUAL_FLAG & flag_q[0];
  assign flag_oe_out.battery_weak = DUAL_FLAG & flag_q[1];

  logic level_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= 1'h0;
    end else begin
      level_q <= 1'h0;
    end
  end
  assign flag_level_out = level_q;

  ////////////////////////////////////////////////////////////////////////////
  // Supply supervisor, no state shared with battery timers

  bmrs_rs_state_t rs_q;
  bmrs_rs_state_t rs_d;
  logic [RSW-1:0] rs_cnt_q;
  logic [RSW-1:0] rs_cnt_d;
  logic rs_done_w;

  assign rs_done_w = (rs_cnt_q == RSW'(RST_CYC - 1));

  // Next state of the supply reset timer
  always_comb begin
    rs_d = rs_q;
    rs_cnt_d = '0;
    unique case (rs_q)
      RS_LOW: begin
        if (cmp_w.supply_ok) begin
          rs_d = RS_WAIT;
        end
      end
      RS_WAIT: begin
        if (!cmp_w.supply_ok) begin
          rs_d = RS_LOW;
        end else if (rs_done_w) begin
          rs_d = RS_OK;
        end else begin
          rs_cnt_d = rs_cnt_q + RSW'(1);
        end
      end
      RS_OK: begin
        if (!cmp_w.supply_ok) begin
          rs_d = RS_LOW;
        end
      end
      default: begin
        rs_d = RS_LOW;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rs_q <= RS_LOW;
      rs_cnt_q <= '0;
    end else begin
      rs_q <= rs_d;
      rs_cnt_q <= rs_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manual reset one-shot and rising-edge debounce

  logic mr_prev_q;
  logic [MRW-1:0] mr_cnt_q;
  logic [DBW-1:0] lock_q;
  logic mr_fire_w;
  logic locked_w;

  assign locked_w = (lock_q != '0);
  // Edge-triggered: a held-low input fires once only
  assign mr_fire_w = mr_prev_q & ~cmp_w.mr_n & ~locked_w;

  // Lockout holds while pressed, then counts out after release
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mr_prev_q <= 1'h1;
      mr_cnt_q <= '0;
      lock_q <= '0;
    end else begin
      mr_prev_q <= cmp_w.mr_n;
      if (mr_fire_w) begin
        mr_cnt_q <= MRW'(MR_CYC);
      end else if (mr_cnt_q != '0) begin
        mr_cnt_q <= mr_cnt_q - MRW'(1);
      end
      if (mr_fire_w || (locked_w && !cmp_w.mr_n)) begin
        lock_q <= DBW'(DEB_CYC);
      end else if (locked_w) begin
        lock_q <= lock_q - DBW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset output stage

  logic rst_assert_w;
  logic rst_n_q;
  logic rst_oe_q;

  assign rst_assert_w = (rs_q != RS_OK) || (mr_cnt_q != '0);

  // Push-pull drives both levels; open-drain only pulls low
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_n_q <= 1'h0;
      rst_oe_q <= 1'h1;
    end else begin
      rst_n_q <= PUSH_PULL ? ~rst_assert_w : 1'h0;
      rst_oe_q <= PUSH_PULL ? 1'h1 : rst_assert_w;
    end
  end
  assign processor_reset_n_out = rst_n_q;
  assign processor_reset_oe_out = rst_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic pin_low_w;
  assign pin_low_w = rst_oe_q && !rst_n_q;

  property p_single_set;
    @(posedge sys_clk_in) disable iff (rst_in)
    !DUAL_FLAG && !cmp_w.low_above |=> flag_oe_out.low_battery;
  endproperty
  a_single_set: assert property (p_single_set)
    else $error("combined flag not set on low input");

  property p_single_release;
    @(posedge sys_clk_in) disable iff (rst_in)
    !DUAL_FLAG && $fell(flag_q[0]) |->
      $past(cmp_w.high_above) && $past(cnt_q[0]) == LBW'(LB_CYC - 1);
  endproperty
  a_single_release: assert property (p_single_release)
    else $error("combined flag released early");

  property p_weak_set;
    @(posedge sys_clk_in) disable iff (rst_in)
    DUAL_FLAG && !cmp_w.high_above |=> flag_oe_out.battery_weak;
  endproperty
  a_weak_set: assert property (p_weak_set)
    else $error("weak flag not set");

  property p_weak_release;
    @(posedge sys_clk_in) disable iff (rst_in)
    DUAL_FLAG && $fell(flag_q[1]) |->
      $past(qual_w[1]) && $past(cnt_q[1]) == LBW'(LB_CYC - 1);
  endproperty
  a_weak_release: assert property (p_weak_release)
    else $error("weak flag released early");

  property p_empty_set;
    @(posedge sys_clk_in) disable iff (rst_in)
    DUAL_FLAG && !cmp_w.low_above |=> flag_oe_out.battery_empty;
  endproperty
  a_empty_set: assert property (p_empty_set)
    else $error("empty flag not set");

  property p_empty_release;
    @(posedge sys_clk_in) disable iff (rst_in)
    DUAL_FLAG && $fell(flag_q[0]) |->
      $past(cmp_w.low_above) && $past(cnt_q[0]) == LBW'(LB_CYC - 1);
  endproperty
  a_empty_release: assert property (p_empty_release)
    else $error("empty flag released early");

  property p_order;
    @(posedge sys_clk_in) disable iff (rst_in)
    DUAL_FLAG && flag_q[0] |=> cnt_q[1] == '0;
  endproperty
  a_order: assert property (p_order)
    else $error("weak timer ran while empty flag set");

  property p_supply_low;
    @(posedge sys_clk_in) disable iff (rst_in)
    !cmp_w.supply_ok |=> ##1 pin_low_w;
  endproperty
  a_supply_low: assert property (p_supply_low)
    else $error("reset not driven low on low supply");

  property p_timeout;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(rs_q == RS_OK) |-> $past(rs_cnt_q) == RSW'(RST_CYC - 1);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("supply reset timeout too short");

  property p_restart;
    @(posedge sys_clk_in) disable iff (rst_in)
    !cmp_w.supply_ok |=> rs_cnt_q == '0 && rs_q == RS_LOW;
  endproperty
  a_restart: assert property (p_restart)
    else $error("supply timeout not restarted");

  property p_mr_pulse;
    @(posedge sys_clk_in) disable iff (rst_in)
    mr_fire_w |=> mr_cnt_q == MRW'(MR_CYC) ##1 pin_low_w;
  endproperty
  a_mr_pulse: assert property (p_mr_pulse)
    else $error("manual reset pulse missing");

  property p_debounce;
    @(posedge sys_clk_in) disable iff (rst_in)
    locked_w && !cmp_w.mr_n |=>
      lock_q == DBW'(DEB_CYC) && mr_cnt_q != MRW'(MR_CYC);
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("manual reset accepted during debounce");

  property p_qual_clear;
    @(posedge sys_clk_in) disable iff (rst_in)
    !qual_w[0] |=> cnt_q[0] == '0;
  endproperty
  a_qual_clear: assert property (p_qual_clear)
    else $error("qualification count kept after drop");

  property p_drive;
    @(posedge sys_clk_in) disable iff (rst_in)
    !level_q && (PUSH_PULL ? rst_oe_q : !rst_n_q);
  endproperty
  a_drive: assert property (p_drive)
    else $error("output drive form wrong");

  c_flag_release: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(flag_q[0]));
  c_reset_release: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(rs_q == RS_OK));
  c_mr_fire: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    mr_fire_w);
  c_weak_release: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(flag_q[1]));

endmodule // bmrs_top

// ### tb/bmrs_host_model.sv
`timescale 1ns/1ps
// Host side: pull-ups on status pins and a pushbutton
module bmrs_host_model #(
  parameter int MPW_CYC = 3
) (
  input wire logic sys_clk_in,
  input wire logic press_in,
  input wire logic hold_in,
  input wire bmrs_pkg::bmrs_flags_t flag_oe_in,
  input wire logic flag_level_in,
  input wire logic reset_n_in,
  input wire logic reset_oe_in,
  output logic manual_reset_n_out,
  output logic [2:0] flag_pin_out,
  output logic reset_pin_out
);
  import bmrs_pkg::*;
  int press_q = 0;
  // Each press stays low long enough to pass the synchroniser
  always_ff @(posedge sys_clk_in) begin
    if (press_in) press_q <= MPW_CYC;
    else if (press_q != 0) press_q <= press_q - 1;
  end
  assign manual_reset_n_out = !(hold_in || press_q != 0);
  // Released pins float up to the pull-up, never to the last value
  assign flag_pin_out[2] = flag_oe_in.low_battery ? flag_level_in : 1'h1;
  assign flag_pin_out[1] = flag_oe_in.battery_weak ? flag_level_in : 1'h1;
  assign flag_pin_out[0] = flag_oe_in.battery_empty ? flag_level_in : 1'h1;
  assign reset_pin_out = reset_oe_in ? reset_n_in : 1'h1;
endmodule // bmrs_host_model

// ### tb/tb_bmrs_top.sv
`timescale 1ns/1ps
module tb_bmrs_top;
  import bmrs_pkg::*;
  // Short counts keep the run brief; expectations derive from them
  localparam int LB = 20;
  localparam int RST = 30;
  localparam int MR = 25;
  localparam int DEB = 40;
  localparam int RA = 0, LOW = 1, RB = 2, WEAK = 3, EMPTY = 4;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic lo = 1'h0, hi = 1'h0, sup = 1'h0, press = 1'h0, hold = 1'h0;
  bmrs_flags_t oe_a, oe_b;
  logic lvl_a, lvl_b, rn_a, rn_b, roe_a, roe_b, mr_a, mr_b, rp_a, rp_b;
  logic [2:0] fp_a, fp_b;
  int miscompares = 0, compares = 0, n, m;
  wire logic [4:0] pin = {fp_b[0], fp_b[1], rp_b, fp_a[2], rp_a};

  // Single flag, open-drain reset
  bmrs_top #(.DUAL_FLAG(1'h0), .PUSH_PULL(1'h0), .LB_CYC(LB),
    .RST_CYC(RST), .MR_CYC(MR), .DEB_CYC(DEB)) bmrs_top_inst (
    .sys_clk_in(sys_clk), .rst_in(rst), .low_thr_above_in(lo),
    .high_thr_above_in(hi), .supply_ok_in(sup), .manual_reset_n_in(mr_a),
    .flag_oe_out(oe_a), .flag_level_out(lvl_a),
    .processor_reset_n_out(rn_a), .processor_reset_oe_out(roe_a));
  bmrs_host_model bmrs_host_model_inst (.sys_clk_in(sys_clk),
    .press_in(press), .hold_in(hold), .flag_oe_in(oe_a),
    .flag_level_in(lvl_a), .reset_n_in(rn_a), .reset_oe_in(roe_a),
    .manual_reset_n_out(mr_a), .flag_pin_out(fp_a), .reset_pin_out(rp_a));
  // Dual flag, push-pull reset
  bmrs_top #(.DUAL_FLAG(1'h1), .PUSH_PULL(1'h1), .LB_CYC(LB),
    .RST_CYC(RST), .MR_CYC(MR), .DEB_CYC(DEB)) bmrs_top_dual_inst (
    .sys_clk_in(sys_clk), .rst_in(rst), .low_thr_above_in(lo),
    .high_thr_above_in(hi), .supply_ok_in(sup), .manual_reset_n_in(mr_b),
    .flag_oe_out(oe_b), .flag_level_out(lvl_b),
    .processor_reset_n_out(rn_b), .processor_reset_oe_out(roe_b));
  bmrs_host_model bmrs_host_model_dual_inst (.sys_clk_in(sys_clk),
    .press_in(press), .hold_in(hold), .flag_oe_in(oe_b),
    .flag_level_in(lvl_b), .reset_n_in(rn_b), .reset_oe_in(roe_b),
    .manual_reset_n_out(mr_b), .flag_pin_out(fp_b), .reset_pin_out(rp_b));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task finish_test;
    $display("Mismatches %0d of %0d compares", miscompares, compares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t pin %b want %b", $time, got, exp);
    end
  endtask

  task check_rng(input int got, input int lo_b, input int hi_b);
    compares++;
    if (got < lo_b || got > hi_b) begin
      miscompares++;
      $display("CHECK FAILED %0t delay %0d not in %0d..%0d", $time, got,
        lo_b, hi_b);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Counts settled edges until a pin shows a level; bounded by lim
  task wait_pin(input int sel, input logic val, input int lim);
    n = 0;
    #1;
    while (pin[sel] !== val && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    check_bit(pin[RA] | pin[RB], 1'h0);
    check_bit(pin[LOW], 1'h0);
    check_bit(lvl_a | lvl_b, 1'h0);
    check_bit(oe_a.battery_weak | oe_b.low_battery, 1'h0);
    check_bit(pin[WEAK] | pin[EMPTY], 1'h0);
  endtask

  task t_supply;
    cyc(1);
    sup <= 1'h1;
    wait_pin(RA, 1'h1, 100);
    check_rng(n, RST + 2, RST + 6);
    check_bit(roe_a, 1'h0);
    check_bit(roe_b & rn_b, 1'h1);
    cyc(1);
    sup <= 1'h0;
    wait_pin(RA, 1'h0, 20);
    check_rng(n, 2, 5);
    cyc(1);
    sup <= 1'h1;
    cyc(10);
    sup <= 1'h0;
    cyc(2);
    sup <= 1'h1;
    wait_pin(RB, 1'h1, 100);
    check_rng(n, RST + 2, RST + 6);
  endtask

  task t_fast_rise;
    cyc(1);
    lo <= 1'h1;
    hi <= 1'h1;
    wait_pin(EMPTY, 1'h1, 100);
    check_rng(n, LB, LB + 4);
    m = n;
    check_bit(pin[WEAK], 1'h0);
    wait_pin(WEAK, 1'h1, 100);
    check_rng(m + n, 2 * LB + 1, 2 * LB + 8);
    check_bit(pin[LOW], 1'h1);
  endtask

  task t_drop;
    cyc(1);
    lo <= 1'h0;
    hi <= 1'h0;
    wait_pin(LOW, 1'h0, 20);
    check_rng(n, 2, 4);
    check_bit(pin[EMPTY] | pin[WEAK], 1'h0);
    cyc(1);
    lo <= 1'h1;
    cyc(LB + 10);
    #1;
    check_bit(pin[LOW], 1'h0);
    check_bit(pin[EMPTY], 1'h1);
    check_bit(pin[WEAK], 1'h0);
    cyc(1);
    hi <= 1'h1;
    cyc(10);
    hi <= 1'h0;
    cyc(2);
    hi <= 1'h1;
    wait_pin(LOW, 1'h1, 100);
    check_rng(n, LB, LB + 4);
    wait_pin(WEAK, 1'h1, 20);
    check_bit(pin[WEAK], 1'h1);
    cyc(1);
    hi <= 1'h0;
    wait_pin(WEAK, 1'h0, 20);
    check_rng(n, 2, 4);
    check_bit(pin[EMPTY] & pin[LOW], 1'h1);
  endtask

  task t_manual;
    cyc(1);
    press <= 1'h1;
    cyc(1);
    press <= 1'h0;
    wait_pin(RA, 1'h0, 20);
    check_rng(n, 2, 6);
    check_bit(rn_b, 1'h0);
    wait_pin(RA, 1'h1, 100);
    check_rng(n, MR - 2, MR + 3);
    check_bit(pin[EMPTY] & ~pin[WEAK], 1'h1);
    cyc(1);
    press <= 1'h1;
    cyc(1);
    press <= 1'h0;
    wait_pin(RA, 1'h0, 10);
    check_rng(n, 10, 10);
    cyc(DEB + 20);
    hold <= 1'h1;
    wait_pin(RA, 1'h0, 20);
    check_rng(n, 2, 6);
    wait_pin(RA, 1'h1, 100);
    check_rng(n, MR - 2, MR + 3);
    cyc(20);
    #1;
    check_bit(pin[RA], 1'h1);
    cyc(1);
    hold <= 1'h0;
    cyc(DEB + 10);
    press <= 1'h1;
    cyc(1);
    press <= 1'h0;
    wait_pin(RA, 1'h0, 20);
    check_rng(n, 2, 6);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(3);
    rst <= 1'h0;
    cyc(2);
    #1;
    t_reset;
    t_supply;
    t_fast_rise;
    t_drop;
    t_manual;
    finish_test;
  end

  // Watchdog: whole run is well under 1000 cycles, so 5000 means a hang
  initial begin
    #50000;
    miscompares++;
    finish_test;
  end
endmodule // tb_bmrs_top
